// >>> hw/output_port_control_bank.sv
// Output port control bank with APB register access
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
//
// Operation
// - Float bit 1 floats its pins; 0 drives them push-pull.
// - All float bits clear at reset, pins start driven.
// - Group byte bits 0-3 float port 0/1 nibbles, low first.
// - Port 2 and 3 float bytes, one bit per pin.
// - Group byte bits 6 and 7 float port 5 pins 0 and 1.
// - Level bit 1 drives high, 0 low; reads back written value.
// - Level bytes for ports 0 to 3 at consecutive indices.
// - Port 5 level bits sit in bits 0 and 1.
// - Reset sets port 5 pin 0 low, all other levels high.
// - Spare float bits and spare byte are plain storage.
// - LCD line sync enable bit, read/write, resets to 0.
// - LCD polarity enable bit, read/write, resets to 0.
// - Duty select: 1 gives 1/16, 0 gives 1/32, resets 0.
// - Fixed 1/8 duty option makes duty writes ignored.
// - Glyph size select: 1 gives 5x5, 0 gives 5x8, resets 0.
// - Timer output source: 1 timer 1, 0 timer 0, resets 0.
// - Prescaler source bits: 1 fast oscillator, 0 slow; reset 0.
// - Writing 1 starts single shot; reads 1 while busy.
// - Writing 1 to the abort bit ends the single shot.
// - Length select: 1 gives 125 ms, 0 gives 31.25 ms.
// - Decay enable held at 0 from the second cycle of a single shot.
// - Start and abort together: abort wins, shot stays idle.
// - Start only while sounder off; retrigger restarts count.
module output_port_control_bank
  import outport_pkg::*;
#(
  parameter int SHOT_SHORT_LEN = SHOT_SHORT_CYCLES,
  parameter int SHOT_LONG_LEN = SHOT_LONG_CYCLES,
  parameter bit FIXED_EIGHTH_DUTY = 1'b0
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Special signal sources
  input wire logic lcd_line_latch_signal,
  input wire logic lcd_ac_toggle_signal,
  input wire logic timer0_clock_output,
  input wire logic timer1_clock_output,
  input wire logic sound_generator_output,
  // Output pins: level and output enable
  output logic [7:0] port0_level,
  output logic [7:0] port0_oe,
  output logic [7:0] port1_level,
  output logic [7:0] port1_oe,
  output logic [7:0] port2_level,
  output logic [7:0] port2_oe,
  output logic [7:0] port3_level,
  output logic [7:0] port3_oe,
  output logic [1:0] port5_level,
  output logic [1:0] port5_oe,
  // Configuration to neighbouring blocks
  output logic lcd_duty_select,
  output logic lcd_glyph_size_select,
  output logic timer_out_source_select,
  output logic timer_pair_mode,
  output logic prescaler0_source_select,
  output logic prescaler1_source_select,
  output logic decay_enable,
  output logic decay_time_select,
  output logic decay_reset,
  output logic sounder_active
);
  logic [7:0] float_group;
  logic [7:0] float_port2;
  logic [7:0] float_port3;
  logic [7:0] level_port0;
  logic [7:0] level_port1;
  logic [7:0] level_port2;
  logic [7:0] level_port3;
  logic [7:0] spare_storage_bits;
  logic [1:0] port5_pin_level;
  logic [4:0] lcd_cfg;
  logic [4:0] timer_cfg;
  logic sounder_enable;
  logic single_shot_length_select;
  logic [PIN_COUNT-1:0] pin_float;
  logic [PIN_COUNT-1:0] pin_data;
  logic [PIN_COUNT-1:0] next_pin_level;
  logic [PIN_COUNT-1:0] pin_level;
  logic [PIN_COUNT-1:0] pin_oe;
  logic [15:0] reg_index;
  logic access;
  logic write_en;
  logic mapped;
  logic [7:0] next_rdata;
  logic timer_clock_output;

  single_shot_if shot ();

  assign reg_index = paddr[ADDR_W-1:2];
  assign access = psel && penable && pready;
  assign write_en = access && pwrite && mapped;

  // Address decode and read mux
  always_comb
  begin
    mapped = 1'b1;
    next_rdata = 8'h00;
    case (reg_index)
      IDX_LCD_OUT_CONFIG: next_rdata = {3'h0, lcd_cfg};
      IDX_TIMER_OUT_PRESCALE_CONFIG: next_rdata = {3'h0, timer_cfg};
      IDX_BUZZER_CTRL:
      begin
        next_rdata[SINGLE_SHOT_BIT] = shot.busy;
        next_rdata[SHOT_LENGTH_BIT] = single_shot_length_select;
        next_rdata[DECAY_TIME_BIT] = decay_time_select;
        next_rdata[DECAY_EN_BIT] = decay_enable;
        next_rdata[SOUNDER_EN_BIT] = sounder_enable;
      end
      IDX_HIZ_CTRL_GROUP: next_rdata = float_group;
      IDX_HIZ_CTRL_PORT2: next_rdata = float_port2;
      IDX_HIZ_CTRL_PORT3: next_rdata = float_port3;
      IDX_OUT_DATA_PORT0: next_rdata = level_port0;
      IDX_OUT_DATA_PORT1: next_rdata = level_port1;
      IDX_OUT_DATA_PORT2: next_rdata = level_port2;
      IDX_OUT_DATA_PORT3: next_rdata = level_port3;
      IDX_SPARE_STORAGE_BYTE: next_rdata = spare_storage_bits;
      IDX_OUT_DATA_PORT5: next_rdata = {6'h00, port5_pin_level};
      default: mapped = 1'b0;
    endcase
  end

  // APB: one wait state, answer registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (psel && penable && !pready && !pwrite)
        prdata <= {24'h00_0000, next_rdata};
    end
  end

  // Float controls and pin levels
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      float_group <= FLOAT_RST;
      float_port2 <= FLOAT_RST;
      float_port3 <= FLOAT_RST;
      level_port0 <= LEVEL_RST;
      level_port1 <= LEVEL_RST;
      level_port2 <= LEVEL_RST;
      level_port3 <= LEVEL_RST;
      spare_storage_bits <= LEVEL_RST;
      port5_pin_level <= PORT5_LEVEL_RST;
    end
    else if (ce && write_en)
    begin
      case (reg_index)
        IDX_HIZ_CTRL_GROUP: float_group <= pwdata[7:0];
        IDX_HIZ_CTRL_PORT2: float_port2 <= pwdata[7:0];
        IDX_HIZ_CTRL_PORT3: float_port3 <= pwdata[7:0];
        IDX_OUT_DATA_PORT0: level_port0 <= pwdata[7:0];
        IDX_OUT_DATA_PORT1: level_port1 <= pwdata[7:0];
        IDX_OUT_DATA_PORT2: level_port2 <= pwdata[7:0];
        IDX_OUT_DATA_PORT3: level_port3 <= pwdata[7:0];
        IDX_SPARE_STORAGE_BYTE: spare_storage_bits <= pwdata[7:0];
        IDX_OUT_DATA_PORT5: port5_pin_level <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // LCD and timer configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lcd_cfg <= CONFIG_RST;
      timer_cfg <= CONFIG_RST;
    end
    else if (ce && write_en)
    begin
      if (reg_index == IDX_LCD_OUT_CONFIG)
      begin
        lcd_cfg <= pwdata[4:0];
        if (FIXED_EIGHTH_DUTY)
          lcd_cfg[LCD_DUTY_BIT] <= 1'b0;
      end
      if (reg_index == IDX_TIMER_OUT_PRESCALE_CONFIG)
        timer_cfg <= pwdata[4:0];
    end
  end

  // Sounder control
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sounder_enable <= 1'b0;
      single_shot_length_select <= 1'b0;
      decay_time_select <= 1'b0;
      decay_enable <= 1'b0;
      decay_reset <= 1'b0;
    end
    else if (ce)
    begin
      decay_reset <= write_en && reg_index == IDX_BUZZER_CTRL
        && pwdata[DECAY_RESET_BIT];
      if (write_en && reg_index == IDX_BUZZER_CTRL)
      begin
        sounder_enable <= pwdata[SOUNDER_EN_BIT];
        single_shot_length_select <= pwdata[SHOT_LENGTH_BIT];
        decay_time_select <= pwdata[DECAY_TIME_BIT];
        decay_enable <= pwdata[DECAY_EN_BIT];
      end
      if (shot.busy)
        decay_enable <= 1'b0;
    end
  end

  assign shot.start = write_en && reg_index == IDX_BUZZER_CTRL
    && pwdata[SINGLE_SHOT_BIT] && !sounder_enable;
  assign shot.stop = write_en && reg_index == IDX_BUZZER_CTRL
    && pwdata[SHOT_ABORT_BIT];
  assign shot.long_sel = pwdata[SHOT_LENGTH_BIT];

  single_shot_timer #(
    .SHORT_CYCLES(SHOT_SHORT_LEN),
    .LONG_CYCLES(SHOT_LONG_LEN)
  ) u_shot (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .shot(shot)
  );

  // Per-pin float select and level
  assign pin_data = {port5_pin_level, level_port3, level_port2,
    level_port1, level_port0};
  genvar i;
  generate
    for (i = 0; i < PIN_COUNT; i++)
    begin : g_pin
      if (i < PORT2_BASE)
      begin : g_nib
        assign pin_float[i] = float_group[i / 4];
      end
      else if (i < PORT3_BASE)
      begin : g_p2
        assign pin_float[i] = float_port2[i - PORT2_BASE];
      end
      else if (i < PORT5_BASE)
      begin : g_p3
        assign pin_float[i] = float_port3[i - PORT3_BASE];
      end
      else
      begin : g_p5
        assign pin_float[i] =
          float_group[FLOAT_PORT5_BASE + i - PORT5_BASE];
      end
    end
  endgenerate

  assign timer_clock_output = timer_cfg[TIMER_OUT_SRC_BIT] ?
    timer1_clock_output : timer0_clock_output;

  // Special outputs replace the level bit while enabled
  always_comb
  begin
    next_pin_level = pin_data;
    if (lcd_cfg[LCD_LINE_SYNC_BIT])
      next_pin_level[PIN_LINE_SYNC] = lcd_line_latch_signal;
    if (lcd_cfg[LCD_POLARITY_BIT])
      next_pin_level[PIN_POLARITY] = lcd_ac_toggle_signal;
    if (timer_cfg[TIMER_OUT_EN_BIT])
      next_pin_level[PIN_TIMER_OUT] = timer_clock_output;
    if (sounder_enable || shot.busy)
      next_pin_level[PIN_SOUNDER] = sound_generator_output;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_level <= {PORT5_LEVEL_RST, {4{LEVEL_RST}}};
      pin_oe <= '1;
      sounder_active <= 1'b0;
    end
    else if (ce)
    begin
      pin_level <= next_pin_level;
      pin_oe <= ~pin_float;
      sounder_active <= sounder_enable || shot.busy;
    end
  end

  assign port0_level = pin_level[7:0];
  assign port1_level = pin_level[15:8];
  assign port2_level = pin_level[23:16];
  assign port3_level = pin_level[31:24];
  assign port5_level = pin_level[33:32];
  assign port0_oe = pin_oe[7:0];
  assign port1_oe = pin_oe[15:8];
  assign port2_oe = pin_oe[23:16];
  assign port3_oe = pin_oe[31:24];
  assign port5_oe = pin_oe[33:32];
  assign lcd_duty_select = lcd_cfg[LCD_DUTY_BIT];
  assign lcd_glyph_size_select = lcd_cfg[LCD_GLYPH_BIT];
  assign timer_out_source_select = timer_cfg[TIMER_OUT_SRC_BIT];
  assign timer_pair_mode = timer_cfg[TIMER_PAIR_MODE_BIT];
  assign prescaler0_source_select = timer_cfg[PRESCALER0_SRC_BIT];
  assign prescaler1_source_select = timer_cfg[PRESCALER1_SRC_BIT];

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  reset_pins_a: assert property ($rose(presetn) |->
    pin_oe == '1 && port5_level == PORT5_LEVEL_RST
    && port0_level == LEVEL_RST)
    else $error("pins not in reset drive state");
  nibble_float_a: assert property (ce && write_en
    && reg_index == IDX_HIZ_CTRL_GROUP ##1 ce
    |=> port0_oe[3:0] == {4{!$past(pwdata[0], 2)}}
    && port1_oe[7:4] == {4{!$past(pwdata[3], 2)}})
    else $error("nibble float control not applied");
  port2_float_a: assert property (ce && write_en
    && reg_index == IDX_HIZ_CTRL_PORT2 ##1 ce
    |=> port2_oe == ~$past(pwdata[7:0], 2))
    else $error("port 2 float control not applied");
  port5_float_a: assert property (ce && write_en
    && reg_index == IDX_HIZ_CTRL_GROUP ##1 ce
    |=> port5_oe == ~$past(pwdata[7:6], 2))
    else $error("port 5 float control not applied");
  port0_level_a: assert property (ce && write_en
    && reg_index == IDX_OUT_DATA_PORT0 ##1 ce
    |=> port0_level == $past(pwdata[7:0], 2))
    else $error("port 0 level not applied");
  port5_read_a: assert property (ce && psel && penable && !pready
    && !pwrite && reg_index == IDX_OUT_DATA_PORT5
    |=> prdata[31:2] == 30'h0000_0000)
    else $error("unimplemented bits read nonzero");
  fixed_duty_a: assert property (FIXED_EIGHTH_DUTY |->
    !lcd_duty_select)
    else $error("duty select set under fixed duty option");
  decay_hold_a: assert property (ce && shot.busy |=>
    !decay_enable)
    else $error("decay enable set during single shot");
  line_sync_a: assert property (ce && lcd_cfg[LCD_LINE_SYNC_BIT]
    |=> port2_level[5] == $past(lcd_line_latch_signal))
    else $error("line sync not routed to pin");
  no_start_a: assert property (ce && write_en
    && reg_index == IDX_BUZZER_CTRL && sounder_enable && !shot.busy
    |=> !shot.busy)
    else $error("single shot started while sounder on");

  read_c: cover property (access && !pwrite);
  float_c: cover property (write_en && reg_index == IDX_HIZ_CTRL_GROUP);
  shot_c: cover property (shot.start ##1 shot.busy);
  abort_c: cover property (shot.busy && shot.stop);
endmodule

// >>> common/outport_pkg.sv
// Constants for the output port control bank
package outport_pkg;
  // Register indices; byte address on APB is four times the index
  localparam logic [15:0] IDX_LCD_OUT_CONFIG = 16'hFF10;
  localparam logic [15:0] IDX_TIMER_OUT_PRESCALE_CONFIG = 16'hFF30;
  localparam logic [15:0] IDX_BUZZER_CTRL = 16'hFF44;
  localparam logic [15:0] IDX_HIZ_CTRL_GROUP = 16'hFF70;
  localparam logic [15:0] IDX_HIZ_CTRL_PORT2 = 16'hFF71;
  localparam logic [15:0] IDX_HIZ_CTRL_PORT3 = 16'hFF72;
  localparam logic [15:0] IDX_OUT_DATA_PORT0 = 16'hFF73;
  localparam logic [15:0] IDX_OUT_DATA_PORT1 = 16'hFF74;
  localparam logic [15:0] IDX_OUT_DATA_PORT2 = 16'hFF75;
  localparam logic [15:0] IDX_OUT_DATA_PORT3 = 16'hFF76;
  localparam logic [15:0] IDX_SPARE_STORAGE_BYTE = 16'hFF77;
  localparam logic [15:0] IDX_OUT_DATA_PORT5 = 16'hFF78;
  localparam int ADDR_W = 18;

  // lcd_out_config fields
  localparam int LCD_SPARE_BIT = 0;
  localparam int LCD_DUTY_BIT = 1;
  localparam int LCD_GLYPH_BIT = 2;
  localparam int LCD_POLARITY_BIT = 3;
  localparam int LCD_LINE_SYNC_BIT = 4;
  // timer_out_prescale_config fields
  localparam int PRESCALER0_SRC_BIT = 0;
  localparam int PRESCALER1_SRC_BIT = 1;
  localparam int TIMER_OUT_EN_BIT = 2;
  localparam int TIMER_OUT_SRC_BIT = 3;
  localparam int TIMER_PAIR_MODE_BIT = 4;
  // buzzer_ctrl fields
  localparam int SOUNDER_EN_BIT = 0;
  localparam int DECAY_EN_BIT = 1;
  localparam int DECAY_RESET_BIT = 2;
  localparam int DECAY_TIME_BIT = 3;
  localparam int SHOT_LENGTH_BIT = 4;
  localparam int SINGLE_SHOT_BIT = 5;
  localparam int SHOT_ABORT_BIT = 6;
  // Float group fields: nibble floats in 3:0, spare in 5:4, port 5 in 7:6
  localparam int FLOAT_SPARE_A_BIT = 4;
  localparam int FLOAT_SPARE_B_BIT = 5;
  localparam int FLOAT_PORT5_BASE = 6;

  // Reset values
  localparam logic [7:0] FLOAT_RST = 8'h00;
  localparam logic [7:0] LEVEL_RST = 8'hFF;
  localparam logic [1:0] PORT5_LEVEL_RST = 2'h2;
  localparam logic [4:0] CONFIG_RST = 5'h00;

  // Flattened pin vector: ports 0..3 in bits 31:0, port 5 in 33:32
  localparam int PIN_COUNT = 34;
  localparam int PORT2_BASE = 16;
  localparam int PORT3_BASE = 24;
  localparam int PORT5_BASE = 32;
  localparam int PIN_LINE_SYNC = 21;
  localparam int PIN_POLARITY = 22;
  localparam int PIN_TIMER_OUT = 23;
  localparam int PIN_SOUNDER = 32;

  // Single-shot lengths
  localparam int CLK_PERIOD_NS = 20;
  localparam int SHOT_SHORT_NS = 31250000;
  localparam int SHOT_LONG_NS = 125000000;
  localparam int SHOT_SHORT_CYCLES = SHOT_SHORT_NS / CLK_PERIOD_NS;
  localparam int SHOT_LONG_CYCLES = SHOT_LONG_NS / CLK_PERIOD_NS;
  localparam int SHOT_CNT_W = 23;
endpackage

// >>> common/single_shot_if.sv
// Handshake between the register bank and the single-shot timer
`timescale 1ns/1ps
interface single_shot_if;
  logic start;
  logic stop;
  logic long_sel;
  logic busy;
  modport ctrl (output start, output stop, output long_sel, input busy);
  modport timer (input start, input stop, input long_sel, output busy);
endinterface

// >>> hw/single_shot_timer.sv
// Single-shot sounder duration timer
`timescale 1ns/1ps
module single_shot_timer
  import outport_pkg::*;
#(
  parameter int SHORT_CYCLES = SHOT_SHORT_CYCLES,
  parameter int LONG_CYCLES = SHOT_LONG_CYCLES
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Control
  single_shot_if.timer shot
);
  localparam logic [SHOT_CNT_W-1:0] SHORT_LOAD =
    SHOT_CNT_W'(SHORT_CYCLES);
  localparam logic [SHOT_CNT_W-1:0] LONG_LOAD =
    SHOT_CNT_W'(LONG_CYCLES);
  localparam logic [SHOT_CNT_W-1:0] CNT_ONE = SHOT_CNT_W'(1);

  logic [SHOT_CNT_W-1:0] remaining;
  logic busy;

  assign shot.busy = busy;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy <= 1'b0;
      remaining <= '0;
    end
    else if (ce)
    begin
      if (shot.stop)
      begin
        busy <= 1'b0;
        remaining <= '0;
      end
      else if (shot.start)
      begin
        busy <= 1'b1;
        remaining <= shot.long_sel ? LONG_LOAD : SHORT_LOAD;
      end
      else if (busy)
      begin
        if (remaining == CNT_ONE)
          busy <= 1'b0;
        remaining <= remaining - CNT_ONE;
      end
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  stop_wins_a: assert property (ce && shot.stop |=> !busy)
    else $error("single shot still busy after abort");
  shot_load_a: assert property (ce && shot.start && !shot.stop
    |=> busy
    && remaining == ($past(shot.long_sel) ? LONG_LOAD : SHORT_LOAD))
    else $error("single shot length loaded wrongly");
  shot_expire_a: assert property (ce && busy && !shot.start
    && !shot.stop && remaining == CNT_ONE |=> !busy)
    else $error("single shot did not end at count expiry");
  shot_done_c: cover property (ce && busy ##1 !busy);
endmodule

// >>> verification/pin_load_model.sv
// Board loads on the output pins, with a pull-down on every pin
`timescale 1ns/1ps
module pin_load_model
  import outport_pkg::*;
(
  // Drive from the bank
  input wire logic [PIN_COUNT-1:0] level,
  input wire logic [PIN_COUNT-1:0] oe,
  // Level seen by the load
  output logic [PIN_COUNT-1:0] pad
);
  // A released pin falls to the pull-down rather than keeping its value
  always_comb pad = level & oe;
endmodule

// >>> verification/output_port_control_bank_test.sv
// Self-checking bench for the output port control bank
`timescale 1ns/1ps
module output_port_control_bank_test;
  import outport_pkg::*;
  localparam int SHORT_LEN = 20;
  localparam int LONG_LEN = 50;
  localparam logic [15:0] REGS [12] = '{IDX_LCD_OUT_CONFIG,
    IDX_TIMER_OUT_PRESCALE_CONFIG, IDX_BUZZER_CTRL, IDX_HIZ_CTRL_GROUP,
    IDX_HIZ_CTRL_PORT2, IDX_HIZ_CTRL_PORT3, IDX_OUT_DATA_PORT0,
    IDX_OUT_DATA_PORT1, IDX_OUT_DATA_PORT2, IDX_OUT_DATA_PORT3,
    IDX_SPARE_STORAGE_BYTE, IDX_OUT_DATA_PORT5};
  localparam logic [7:0] RST_VAL [12] = '{8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h02};
  localparam logic [7:0] WR_MASK [12] = '{8'h1F, 8'h1F, 8'h00, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h03};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic sync_src = 1'b0;
  logic pol_src = 1'b0;
  logic tmr0_src = 1'b0;
  logic tmr1_src = 1'b0;
  logic sound_src = 1'b1;
  logic [7:0] lv0, lv1, lv2, lv3, oe0, oe1, oe2, oe3;
  logic [1:0] lv5, oe5;
  logic duty, glyph, tsrc, pair, pre0, pre1, decay, dtime, drst, sact;
  logic [PIN_COUNT-1:0] pad;
  int err_count = 0;
  int n_compared = 0;

  always #10 pclk = ~pclk;

  output_port_control_bank #(.SHOT_SHORT_LEN(SHORT_LEN),
    .SHOT_LONG_LEN(LONG_LEN)) u_dut (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lcd_line_latch_signal(sync_src),
    .lcd_ac_toggle_signal(pol_src), .timer0_clock_output(tmr0_src),
    .timer1_clock_output(tmr1_src), .sound_generator_output(sound_src),
    .port0_level(lv0), .port0_oe(oe0), .port1_level(lv1), .port1_oe(oe1),
    .port2_level(lv2), .port2_oe(oe2), .port3_level(lv3), .port3_oe(oe3),
    .port5_level(lv5), .port5_oe(oe5), .lcd_duty_select(duty),
    .lcd_glyph_size_select(glyph), .timer_out_source_select(tsrc),
    .timer_pair_mode(pair), .prescaler0_source_select(pre0),
    .prescaler1_source_select(pre1), .decay_enable(decay),
    .decay_time_select(dtime), .decay_reset(drst), .sounder_active(sact));

  pin_load_model u_load (.level({lv5, lv3, lv2, lv1, lv0}),
    .oe({oe5, oe3, oe2, oe1, oe0}), .pad(pad));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // One APB transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [15:0] idx,
    input logic [7:0] wd, output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 20)
      err_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask

  task automatic rdchk(input logic [15:0] idx, input logic [7:0] exp,
    input logic experr = 1'b0);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 8'h00, r, e);
    chk({e, r}, {experr, 24'h000000, exp});
  endtask

  // Pins follow a write one edge after its completion
  task automatic settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask

  task automatic t_regs;
    foreach (REGS[i]) rdchk(REGS[i], RST_VAL[i]);
    for (int i = 0; i < 12; i++)
      if (i != 2)
        wr(REGS[i], 8'hFF);
    for (int i = 0; i < 12; i++)
      if (i != 2)
        rdchk(REGS[i], WR_MASK[i]);
    for (int i = 0; i < 12; i++)
      if (i != 2)
        wr(REGS[i], 8'h00);
    for (int i = 0; i < 12; i++)
      if (i != 2)
        rdchk(REGS[i], 8'h00);
  endtask

  task automatic t_pins;
    wr(IDX_OUT_DATA_PORT0, 8'hA5);
    wr(IDX_OUT_DATA_PORT1, 8'h3C);
    wr(IDX_OUT_DATA_PORT2, 8'h0F);
    wr(IDX_OUT_DATA_PORT3, 8'h96);
    wr(IDX_OUT_DATA_PORT5, 8'h01);
    settle;
    chk({lv5, lv3, lv2, lv1, lv0}, {2'h1, 32'h960F3CA5});
    chk({oe5, oe3, oe2, oe1, oe0}, {2'h3, 32'hFFFFFFFF});
    wr(IDX_HIZ_CTRL_GROUP, 8'h75);
    wr(IDX_HIZ_CTRL_PORT2, 8'h81);
    wr(IDX_HIZ_CTRL_PORT3, 8'h18);
    settle;
    chk({oe5, oe3, oe2, oe1, oe0}, {2'h2, 32'hE77EF0F0});
    chk(pad, {2'h0, 32'h860E30A0});
    rdchk(IDX_HIZ_CTRL_GROUP, 8'h75);
  endtask

  task automatic t_special;
    wr(IDX_OUT_DATA_PORT2, 8'hFF);
    pol_src <= 1'b1;
    tmr0_src <= 1'b1;
    wr(IDX_LCD_OUT_CONFIG, 8'h18);
    settle;
    chk({lv2[6:5], duty, glyph}, 4'h8);
    // Clock enable low must freeze the routed pin
    @(posedge pclk);
    ce <= 1'b0;
    sync_src <= 1'b1;
    settle;
    chk(lv2[5], 1'b0);
    @(posedge pclk);
    ce <= 1'b1;
    settle;
    chk(lv2[5], 1'b1);
    wr(IDX_LCD_OUT_CONFIG, 8'h06);
    settle;
    chk({lv2[6:5], duty, glyph}, 4'hF);
    wr(IDX_TIMER_OUT_PRESCALE_CONFIG, 8'h1F);
    settle;
    chk({lv2[7], tsrc, pre1, pre0, pair}, 5'h0F);
    wr(IDX_TIMER_OUT_PRESCALE_CONFIG, 8'h04);
    settle;
    chk({lv2[7], tsrc, pair}, 3'h4);
    rdchk(16'hFF40, 8'h00, 1'b1);
  endtask

  task automatic t_shot;
    wr(IDX_BUZZER_CTRL, 8'h0E);
    #1;
    chk(drst, 1'b1);
    settle;
    chk({decay, dtime, drst}, 3'h6);
    rdchk(IDX_BUZZER_CTRL, 8'h0A);
    wr(IDX_BUZZER_CTRL, 8'h22);
    rdchk(IDX_BUZZER_CTRL, 8'h20);
    chk({sact, decay, lv5[0]}, 3'h5);
    repeat (25) @(posedge pclk);
    rdchk(IDX_BUZZER_CTRL, 8'h00);
    wr(IDX_BUZZER_CTRL, 8'h30);
    repeat (35) @(posedge pclk);
    rdchk(IDX_BUZZER_CTRL, 8'h30);
    repeat (20) @(posedge pclk);
    rdchk(IDX_BUZZER_CTRL, 8'h10);
    wr(IDX_BUZZER_CTRL, 8'h30);
    repeat (35) @(posedge pclk);
    wr(IDX_BUZZER_CTRL, 8'h30);
    repeat (35) @(posedge pclk);
    rdchk(IDX_BUZZER_CTRL, 8'h30);
    wr(IDX_BUZZER_CTRL, 8'h50);
    rdchk(IDX_BUZZER_CTRL, 8'h10);
    wr(IDX_BUZZER_CTRL, 8'h70);
    rdchk(IDX_BUZZER_CTRL, 8'h10);
    wr(IDX_BUZZER_CTRL, 8'h01);
    wr(IDX_BUZZER_CTRL, 8'h21);
    rdchk(IDX_BUZZER_CTRL, 8'h01);
  endtask

  initial
  begin
    repeat (5) @(posedge pclk);
    #1;
    chk({lv5, lv3, lv2, lv1, lv0}, {2'h2, 32'hFFFFFFFF});
    chk({oe5, oe3, oe2, oe1, oe0}, {2'h3, 32'hFFFFFFFF});
    @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_pins;
    t_special;
    t_shot;
    summarize;
  end

  // Cuts a hang short well after the expected run length
  initial
  begin
    #200000;
    err_count++;
    summarize;
  end
endmodule
